// *** rtl/dpbs_pkg.sv ***
// package of constants and carrier types for the dual-port semaphore host controller
package dpbs_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 14;
  localparam int DATA_W        = 16;
  localparam int SEM_IDX_W     = 3;
  localparam int CLK_PERIOD_NS = 10;
  // least hold of the write strobe after the contention flag goes high
  localparam int WRITE_HOLD_AFTER_RELEASE_NS = 20;
  localparam int WRITE_HOLD_CYC =
    (WRITE_HOLD_AFTER_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least lead of the flag input before the write strobe
  localparam int FLAG_INPUT_TO_WRITE_LEAD_NS = 0;
  localparam int FLAG_LEAD_CYC = (FLAG_INPUT_TO_WRITE_LEAD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS < 1 ? 1 : (FLAG_INPUT_TO_WRITE_LEAD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // strobe low and recovery phases of one access, in cycles
  localparam int STROBE_CYC    = 3;
  localparam int RECOVER_CYC   = 1;
  localparam logic [DATA_W-1:0] SEM_REQUEST = 16'h0000;
  localparam logic [DATA_W-1:0] SEM_RELEASE = 16'h0001;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DPBS_RAM_RD, DPBS_RAM_WR, DPBS_SEM_RD, DPBS_SEM_WR} dpbs_op_e;

  typedef struct packed {
    dpbs_op_e          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        byte_en;
  } dpbs_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              sem_owned;
    logic              write_stalled;
  } dpbs_rsp_s;

  typedef struct packed {
    logic              port_select_n;
    logic              semaphore_select_n;
    logic              read_write_n;
    logic              output_enable_n;
    logic              upper_byte_enable_n;
    logic              lower_byte_enable_n;
    logic [ADDR_W-1:0] addr;
  } dpbs_pins_s;
endpackage

// *** rtl/dpbs_host.sv ***
// host controller that drives one port of the dual-port ram with contention flag
`timescale 1ns/1ps
module dpbs_host
  import dpbs_pkg::*;
#(
  parameter int HOLD_CYC = dpbs_pkg::WRITE_HOLD_CYC
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // request side
  input  wire logic                       req_valid,
  input  wire dpbs_pkg::dpbs_req_s        req,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output dpbs_pkg::dpbs_rsp_s             rsp,
  // device pins
  output dpbs_pkg::dpbs_pins_s            pins,
  input  wire logic [dpbs_pkg::DATA_W-1:0] data_in,
  output logic [dpbs_pkg::DATA_W-1:0]     data_out,
  output logic                            data_oe,
  input  wire logic                       contention_flag_n
);
  import dpbs_pkg::*;

  // the hold counter is eight bits wide and must run at least once
  if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_hold_check
    $error("HOLD_CYC out of range");
  end

  // ----------------------------------------------------------------
  // flag synchroniser
  // ----------------------------------------------------------------
  // read data passes two flops as well; output enable is low three edges before
  // recover, so the synchronised word has long settled when it is captured
  logic              flag_meta_reg;
  logic              flag_sync_reg;
  logic [DATA_W-1:0] data_meta_reg;
  logic [DATA_W-1:0] data_sync_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_meta_reg <= 1'b1;
      flag_sync_reg <= 1'b1;
      data_meta_reg <= 16'h0000;
      data_sync_reg <= 16'h0000;
    end else begin
      flag_meta_reg <= contention_flag_n;
      flag_sync_reg <= flag_meta_reg;
      data_meta_reg <= data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_STALL, ST_HOLD, ST_RECOVER}
    dpbs_state_e;

  dpbs_state_e       state_reg, state_next;
  dpbs_req_s         cur_reg, cur_next;
  dpbs_pins_s        pins_reg, pins_next;
  logic [7:0]        cnt_reg, cnt_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic              doe_reg, doe_next;
  logic              rv_reg, rv_next;
  dpbs_rsp_s         rsp_reg, rsp_next;
  logic              stalled_reg, stalled_next;
  logic              is_write;
  logic              is_sem;

  assign is_write = (cur_reg.op == DPBS_RAM_WR) || (cur_reg.op == DPBS_SEM_WR);
  assign is_sem   = (cur_reg.op == DPBS_SEM_RD) || (cur_reg.op == DPBS_SEM_WR);

  always_comb begin
    state_next   = state_reg;
    cur_next     = cur_reg;
    pins_next    = pins_reg;
    cnt_next     = cnt_reg;
    dout_next    = dout_reg;
    doe_next     = doe_reg;
    rv_next      = 1'b0;
    rsp_next     = rsp_reg;
    stalled_next = stalled_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          cur_next     = req;
          stalled_next = 1'b0;
          pins_next.addr = req.addr;
          if (req.op == DPBS_SEM_RD || req.op == DPBS_SEM_WR) begin
            // semaphore space: port select high, semaphore select low
            pins_next.port_select_n      = 1'b1;
            pins_next.semaphore_select_n = 1'b0;
            // only low three address bits pick the latch
            pins_next.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, req.addr[SEM_IDX_W-1:0]};
          end else begin
            pins_next.port_select_n      = 1'b0;
            pins_next.semaphore_select_n = 1'b1;
          end
          // semaphore writes carry only bit 0; 0 requests, 1 releases
          dout_next = (req.op == DPBS_SEM_WR) ?
            (req.wdata[0] ? SEM_RELEASE : SEM_REQUEST) : req.wdata;
          pins_next.upper_byte_enable_n = ~req.byte_en[1];
          pins_next.lower_byte_enable_n = ~req.byte_en[0];
          cnt_next   = 8'(FLAG_LEAD_CYC);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // let address and select settle so the flag is valid before the strobe
        if (cnt_reg > 8'h01) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          pins_next.read_write_n    = ~is_write;
          pins_next.output_enable_n = is_write;
          doe_next   = is_write;
          cnt_next   = 8'(STROBE_CYC);
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (is_write && !is_sem && !flag_sync_reg) begin
          // write is blocked while flag is low; keep strobe active
          stalled_next = 1'b1;
          state_next   = ST_STALL;
        end else if (cnt_reg > 8'h01) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          state_next = ST_RECOVER;
        end
      end
      ST_STALL: begin
        if (flag_sync_reg) begin
          cnt_next   = 8'(HOLD_CYC);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // strobe held after flag release so the blocked write completes
        if (cnt_reg > 8'h01) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        rsp_next.rdata         = data_sync_reg;
        // semaphore read: all bits equal the latch, low means owned
        rsp_next.sem_owned     = (cur_reg.op == DPBS_SEM_RD) && !data_sync_reg[0];
        rsp_next.write_stalled = stalled_reg;
        rv_next  = 1'b1;
        pins_next.read_write_n        = 1'b1;
        pins_next.output_enable_n     = 1'b1;
        pins_next.port_select_n       = 1'b1;
        pins_next.semaphore_select_n  = 1'b1;
        pins_next.upper_byte_enable_n = 1'b1;
        pins_next.lower_byte_enable_n = 1'b1;
        doe_next   = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      cur_reg     <= '0;
      pins_reg    <= '{port_select_n: 1'b1, semaphore_select_n: 1'b1, read_write_n: 1'b1,
                       output_enable_n: 1'b1, upper_byte_enable_n: 1'b1,
                       lower_byte_enable_n: 1'b1, addr: '0};
      cnt_reg     <= 8'h00;
      dout_reg    <= 16'h0000;
      doe_reg     <= 1'b0;
      rv_reg      <= 1'b0;
      rsp_reg     <= '0;
      stalled_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cur_reg     <= cur_next;
      pins_reg    <= pins_next;
      cnt_reg     <= cnt_next;
      dout_reg    <= dout_next;
      doe_reg     <= doe_next;
      rv_reg      <= rv_next;
      rsp_reg     <= rsp_next;
      stalled_reg <= stalled_next;
    end
  end

  assign req_ready = (state_reg == ST_IDLE);
  assign rsp_valid = rv_reg;
  assign rsp       = rsp_reg;
  assign pins      = pins_reg;
  assign data_out  = dout_reg;
  assign data_oe   = doe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_stall_release;
    (state_reg == ST_STALL) ##1 (state_reg == ST_HOLD);
  endsequence

  AST_STALL_KEEPS_STROBE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_reg == ST_STALL) |-> !pins_reg.read_write_n)
    else $error("strobe dropped while write stalled");

  AST_HOLD_AFTER_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_stall_release |-> !pins_reg.read_write_n [*2])
    else $error("strobe not held after flag release");

  AST_SEM_SELECT: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins_reg.semaphore_select_n |-> pins_reg.port_select_n)
    else $error("semaphore select with port select low");

  AST_SEM_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins_reg.semaphore_select_n |-> (pins_reg.addr[ADDR_W-1:SEM_IDX_W] == '0))
    else $error("semaphore address above low bits");

  AST_SEM_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
    (doe_reg && !pins_reg.semaphore_select_n) |-> (dout_reg[DATA_W-1:1] == '0))
    else $error("semaphore write data beyond bit 0");

  AST_LEAD_BEFORE_STROBE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(pins_reg.read_write_n) |-> $past(state_reg) == ST_SETUP)
    else $error("strobe without setup lead");
endmodule // dpbs_host

// *** dv/dpbs_dev_model.sv ***
// behavioural model of the dual-port ram with busy logic and semaphores
`timescale 1ns/1ps
module dpbs_dev_model
  import dpbs_pkg::*;
(
  // left port, host side
  input  wire dpbs_pkg::dpbs_pins_s lp,
  input  wire logic [15:0]          ld,
  output logic [15:0]               lq,
  output logic                      flag_l_n,
  // right port, bench side
  input  wire dpbs_pkg::dpbs_pins_s rp,
  input  wire logic                 rd0,
  output logic [15:0]               rq,
  output logic                      flag_r_n,
  // mode pin and slave flag input
  input  wire logic                 master,
  input  wire logic                 slave_flag_n
);
  import dpbs_pkg::*;
  logic [15:0] mem [16];
  logic [1:0]  own [8];
  logic [7:0]  pend [3];
  logic [15:0] vl;
  logic        hit;
  realtime     tl, tr;
  // ---------------------------------------------------------------
  // arbitration and latches; events are serialised, so ties go right
  // ---------------------------------------------------------------
  initial begin
    foreach (own[i]) own[i] = 2'd0;
    foreach (pend[i]) pend[i] = 8'h00;
  end
  always @(lp.port_select_n or lp.addr) tl = $realtime;
  always @(rp.port_select_n or rp.addr) tr = $realtime;
  assign hit = !lp.port_select_n && !rp.port_select_n && lp.addr == rp.addr;
  assign flag_l_n = master ? !(hit && tl >= tr) : slave_flag_n;
  assign flag_r_n = master ? !(hit && tr > tl) : 1'b1;
  task automatic sem_wr(input logic [1:0] s, input logic [2:0] i, input logic b);
    pend[s][i] = !b;
    if (!b && own[i] == 2'd0) own[i] = s;
    else if (b && own[i] == s) own[i] = pend[~s][i] ? ~s : 2'd0;
  endtask
  // host drops strobe and selects on one edge: keep what stood while strobe was low
  dpbs_pins_s  lw;
  logic [15:0] lwd;
  logic        lwf;
  always @(lp or ld or flag_l_n)
    if (!lp.read_write_n) begin
      lw = lp;
      lwd = ld;
      lwf = flag_l_n;
    end
  always @(posedge lp.read_write_n) begin
    if (!lw.semaphore_select_n && lw.port_select_n) sem_wr(2'd1, lw.addr[2:0], lwd[0]);
    else if (!lw.port_select_n && lwf) mem[lw.addr[3:0]] = lwd;
  end
  always @(posedge rp.read_write_n)
    if (!rp.semaphore_select_n && rp.port_select_n) sem_wr(2'd2, rp.addr[2:0], rd0);
  assign vl = !lp.semaphore_select_n ? {16{own[lp.addr[2:0]] != 2'd1}} : mem[lp.addr[3:0]];
  // released lines show the inverse, so a late sample cannot pass
  assign lq = lp.output_enable_n ? ~vl : vl;
  assign rq = {16{own[rp.addr[2:0]] != 2'd2}};
endmodule // dpbs_dev_model

// *** dv/tb.sv ***
// self-checking bench for the dual-port host controller
`timescale 1ns/1ps
module tb;
  import dpbs_pkg::*;
  logic        mclk = 0, rst_n = 0, req_valid = 0, master = 1, slave_flag_n = 1, rd0 = 1;
  logic        req_ready, rsp_valid, data_oe, flag_l_n, flag_r_n;
  logic [15:0] data_in, data_out, rq, d;
  logic [13:0] a;
  logic [31:0] steps;
  dpbs_req_s   req = '0;
  dpbs_rsp_s   rsp, r;
  dpbs_pins_s  pins, rp = '1;
  int          err_count = 0, n_tests = 0, cyc = 0;
  integer      seed = 32'h15cde406;
  always #5 mclk = ~mclk;
  dpbs_host dpbs_host_inst (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .contention_flag_n(flag_l_n));
  dpbs_dev_model dpbs_dev_model_inst (.lp(pins), .ld(data_out), .lq(data_in),
    .flag_l_n(flag_l_n), .rp(rp), .rd0(rd0), .rq(rq), .flag_r_n(flag_r_n),
    .master(master), .slave_flag_n(slave_flag_n));
  // ---------------------------------------------------------------
  // tasks and sequence
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // host is idle on entry, so the request is taken at the next edge
  task automatic xfer(input dpbs_op_e op, input logic [13:0] ad, input logic [15:0] wd);
    int n;
    n = 0;
    @(negedge mclk);
    req_valid = 1;
    req = '{op, ad, wd, 2'b11};
    @(negedge mclk);
    req_valid = 0;
    while (n < 200 && rsp_valid !== 1'b1) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) err_count++;
    r = rsp;
  endtask
  task automatic rsem(input logic [2:0] i, input logic b);
    @(negedge mclk);
    rp.addr = 14'(i);
    rp.semaphore_select_n = 0;
    rp.read_write_n = 0;
    rd0 = b;
    @(negedge mclk);
    rp.read_write_n = 1;
    @(negedge mclk);
    rp.semaphore_select_n = 1;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1;
    chk("idle select", 16'(pins.port_select_n & req_ready), 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      xfer(DPBS_SEM_RD, 14'(i), 16'h0000);
      chk("sem free", r.rdata, 16'hffff);
      // nibbles: writer is left, value, left reads, right reads
      steps = 32'h91ea_5f27;
      repeat (8) begin
        a = 14'($random(seed));
        a[2:0] = i[2:0];
        d = 16'($random(seed));
        if (steps[31]) xfer(DPBS_SEM_WR, a, {d[15:1], steps[30]});
        else rsem(i[2:0], steps[30]);
        xfer(DPBS_SEM_RD, a ^ 14'h3ff8, 16'h0000);
        chk("left sem", r.rdata, {16{steps[29]}});
        chk("left owned", 16'(r.sem_owned), 16'(!steps[29]));
        rp.addr = 14'(i);
        #1;
        chk("right sem", rq, {16{steps[28]}});
        steps = steps << 4;
      end
    end
    $display("test semaphores done");
    for (int k = 0; k < 2; k++) begin
      master = (k == 0);
      a = 14'($random(seed));
      d = 16'($random(seed));
      xfer(DPBS_RAM_WR, a, ~d);
      chk("no stall", 16'(r.write_stalled), 16'h0000);
      @(negedge mclk);
      rp.addr = a;
      rp.port_select_n = !master;
      slave_flag_n = master;
      fork
        xfer(DPBS_RAM_WR, a, d);
        begin
          repeat (12) @(negedge mclk);
          chk("stall drive", 16'({data_oe, pins.read_write_n}), 16'h0002);
          rp.port_select_n = 1;
          slave_flag_n = 1;
        end
      join
      chk("stalled", 16'(r.write_stalled), 16'h0001);
      xfer(DPBS_RAM_RD, a, 16'h0000);
      chk("ram data", r.rdata, d);
    end
    $display("test contention done");
    summarize();
  end
endmodule // tb
